// *** verilog/mmct_params.svh ***
`ifndef MMCT_PARAMS_SVH
`define MMCT_PARAMS_SVH
`define MMCT_CLK_HZ 10000000
`define MMCT_INIT_MS 2000
`define MMCT_INIT_CYC ((`MMCT_INIT_MS * (`MMCT_CLK_HZ / 1000)))
`define MMCT_RST_PULSE_US 2
`define MMCT_RST_PULSE_CYC (((`MMCT_RST_PULSE_US * `MMCT_CLK_HZ) + 999999) / 1000000)
`define MMCT_LOW_POWER_REQUEST_US 100
`define MMCT_LOW_POWER_REQUEST_CYC ((`MMCT_LOW_POWER_REQUEST_US * `MMCT_CLK_HZ) / 1000000)
`define MMCT_SEL_US 100
`define MMCT_SEL_CYC ((`MMCT_SEL_US * `MMCT_CLK_HZ) / 1000000)
`define MMCT_PDOWN_MS 100
`define MMCT_PDOWN_CYC ((`MMCT_PDOWN_MS * (`MMCT_CLK_HZ / 1000)))
`define MMCT_PUP_MS 300
`define MMCT_PUP_CYC ((`MMCT_PUP_MS * (`MMCT_CLK_HZ / 1000)))
`define MMCT_NFLAGS 8
`define MMCT_FLAG_LOS 0
`define MMCT_FLAG_TXF 1
`define MMCT_FLAG_NOTREADY_BIT 0
`endif

// *** verilog/mmct_pkg.sv ***
package mmct_pkg;
	typedef enum logic [3:0] {
		MMCT_INIT = 4'h1,
		MMCT_READY = 4'h2,
		MMCT_LOWPWR = 4'h4,
		MMCT_WAKE = 4'h8
	} mmct_state_t;
	typedef logic [7:0] mmct_flags_t;
endpackage

// *** verilog/mmct_evt_if.sv ***
`timescale 1ns/1ns
interface mmct_evt_if;
	logic rd_pulse;
	logic wr_pulse;
	logic [7:0] mask;
	logic pdown;
	modport src (output rd_pulse, output wr_pulse, output mask, output pdown);
	modport dst (input rd_pulse, input wr_pulse, input mask, input pdown);
endinterface

// *** verilog/mmct_sync.sv ***
`timescale 1ns/1ns
module mmct_sync (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic d_in,
	output logic q_out
);
	logic s1_q;
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s1_q <= 1'h0;
			q_out <= 1'h0;
		end
		else
		begin
			s1_q <= d_in;
			q_out <= s1_q;
		end
	end
endmodule // mmct_sync

// *** verilog/mmct_link.sv ***
`timescale 1ns/1ns
// link-clock side: host's read/write strobes and mask/pdown words, crossed by toggle
module mmct_link (
	input wire logic link_clk_in,
	input wire logic link_rstn_in,
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic rd_done_in,
	input wire logic wr_done_in,
	input wire logic [7:0] mask_in,
	input wire logic pdown_in,
	mmct_evt_if.src evt
);
	logic rd_tog_q;
	logic wr_tog_q;
	logic [7:0] mask_hold_q;
	logic pdown_hold_q;
	logic rd_s_q;
	logic wr_s_q;
	logic rd_prev_q;
	logic wr_prev_q;
	logic [7:0] mask_q;
	logic pdown_q;
	// strobes taken on the falling edge after stop
	always_ff @(negedge link_clk_in or negedge link_rstn_in)
	begin
		if (!link_rstn_in)
		begin
			rd_tog_q <= 1'h0;
			wr_tog_q <= 1'h0;
			mask_hold_q <= 8'h00;
			pdown_hold_q <= 1'h0;
		end
		else
		begin
			if (rd_done_in)
				rd_tog_q <= ~rd_tog_q;
			if (wr_done_in)
			begin
				wr_tog_q <= ~wr_tog_q;
				mask_hold_q <= mask_in;
				pdown_hold_q <= pdown_in;
			end
		end
	end
	mmct_sync u_rd (.clk_in(ref_clk_in), .rstn_in(rstn_in), .d_in(rd_tog_q), .q_out(rd_s_q));
	mmct_sync u_wr (.clk_in(ref_clk_in), .rstn_in(rstn_in), .d_in(wr_tog_q), .q_out(wr_s_q));
	// held words are stable for many ref cycles once the toggle arrives
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rd_prev_q <= 1'h0;
			wr_prev_q <= 1'h0;
			mask_q <= 8'h00;
			pdown_q <= 1'h0;
		end
		else
		begin
			rd_prev_q <= rd_s_q;
			wr_prev_q <= wr_s_q;
			if (wr_s_q != wr_prev_q)
			begin
				mask_q <= mask_hold_q;
				pdown_q <= pdown_hold_q;
			end
		end
	end
	assign evt.rd_pulse = rd_s_q ^ rd_prev_q;
	assign evt.wr_pulse = wr_s_q ^ wr_prev_q;
	assign evt.mask = mask_q;
	assign evt.pdown = pdown_q;
endmodule // mmct_link

// *** verilog/mmct_top.sv ***
`timescale 1ns/1ns
`include "mmct_params.svh"
// How it works
// (R1) fully functional within 2000 ms after start
// (R2) reset only when low beyond 2 us
// (R3) serial bus answers within 2000 ms
// (R4) clear not-ready bit, assert attention
// (R5) after reset rise, functional within 2000 ms
// (R6) low power within 100 us of request
// (R7) unmasked condition drives attention within 200 ms
// (R8) read clears flag, attention releases quickly
// (R9) signal loss flag set within 100 ms
// (R10) transmit fault flag set within 200 ms
// (R11) other flags set within 200 ms
// (R12) mask set inhibits attention within 100 ms
// (R13) mask clear resumes attention within 100 ms
// (R14) select asserted: respond within 100 us
// (R15) select released: stop within 100 us
// (R16) power-down bit: low power within 100 ms
// (R17) power-down cleared: functional within 300 ms
// (R18) functional means not-ready cleared, attention asserted; code asserts attention only at init end, not on return from low power
// (R19) write timing from falling edge after stop
// (R20) flags sticky until read; attention ORs unmasked
// (R21) all limits from internal cycle counters
module mmct_top #(
	parameter int INIT_CYC = `MMCT_INIT_CYC,
	parameter int PUP_CYC = `MMCT_PUP_CYC,
	parameter int PDOWN_CYC = `MMCT_PDOWN_CYC
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic link_clk_in,
	input wire logic module_reset_n_in,
	input wire logic low_power_request_in,
	input wire logic module_select_n_in,
	input wire logic [7:0] condition_in,
	input wire logic flag_read_done_in,
	input wire logic write_done_in,
	input wire logic [7:0] mask_wr_in,
	input wire logic pdown_wr_in,
	output logic attention_out_n_out,
	output logic bus_respond_out,
	output logic low_power_out,
	output logic fully_functional_out,
	output logic data_not_ready_out,
	output logic [7:0] flags_out
);
	localparam int RST_PULSE_CYC = `MMCT_RST_PULSE_CYC;
	localparam int LP_CYC = `MMCT_LOW_POWER_REQUEST_CYC;
	localparam int SEL_CYC = `MMCT_SEL_CYC;
	logic rst_s1_q;
	logic rstn_q;
	logic mrst_s_q;
	logic lpreq_s_q;
	logic sel_n_s_q;
	logic [7:0] cond_s;
	logic [7:0] rst_cnt_q;
	logic mod_rst_q;
	logic [31:0] tmr_q;
	logic [11:0] lp_cnt_q;
	logic [11:0] sel_cnt_q;
	logic [31:0] pd_cnt_q;
	logic pd_eff_q;
	logic lp_eff_q;
	logic bus_ready_q;
	logic not_ready_q;
	logic ready_attn_q;
	mmct_pkg::mmct_flags_t flags_q;
	mmct_pkg::mmct_state_t state_q;
	logic link_rstn;
	logic link_rst_s1_q;
	logic link_rstn_q;
	mmct_evt_if evt ();

	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rst_s1_q <= 1'h0;
			rstn_q <= 1'h0;
		end
		else
		begin
			rst_s1_q <= 1'h1;
			rstn_q <= rst_s1_q;
		end
	end
	// link side gets its own release, so no link flop leaves reset mid-edge
	always_ff @(posedge link_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			link_rst_s1_q <= 1'h0;
			link_rstn_q <= 1'h0;
		end
		else
		begin
			link_rst_s1_q <= 1'h1;
			link_rstn_q <= link_rst_s1_q;
		end
	end
	assign link_rstn = link_rstn_q;

	mmct_sync u_mrst (.clk_in(ref_clk_in), .rstn_in(rstn_q), .d_in(module_reset_n_in), .q_out(mrst_s_q));
	mmct_sync u_lp (.clk_in(ref_clk_in), .rstn_in(rstn_q), .d_in(low_power_request_in), .q_out(lpreq_s_q));
	mmct_sync u_sel (.clk_in(ref_clk_in), .rstn_in(rstn_q), .d_in(module_select_n_in), .q_out(sel_n_s_q));
	genvar gi;
	generate
		for (gi = 0; gi < `MMCT_NFLAGS; gi++)
		begin : g_cond
			mmct_sync u_c (.clk_in(ref_clk_in), .rstn_in(rstn_q), .d_in(condition_in[gi]), .q_out(cond_s[gi]));
		end
	endgenerate

	mmct_link u_link (
		.link_clk_in(link_clk_in),
		.link_rstn_in(link_rstn),
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_q),
		.rd_done_in(flag_read_done_in),
		.wr_done_in(write_done_in),
		.mask_in(mask_wr_in),
		.pdown_in(pdown_wr_in),
		.evt(evt)
	);

	// glitch filter: short low pulses are ignored
	always_ff @(posedge ref_clk_in or negedge rstn_q)
	begin
		if (!rstn_q)
		begin
			rst_cnt_q <= 8'h00;
			mod_rst_q <= 1'h0;
		end
		else if (mrst_s_q)
		begin
			rst_cnt_q <= 8'h00;
			mod_rst_q <= 1'h0;
		end
		else if (rst_cnt_q >= 8'(RST_PULSE_CYC)) // R2
			mod_rst_q <= 1'h1;
		else
			rst_cnt_q <= rst_cnt_q + 8'h01;
	end

	// sequencer; init compare sits two counts under the limit, so the registered outputs change at about the limit itself
	always_ff @(posedge ref_clk_in or negedge rstn_q)
	begin
		if (!rstn_q)
		begin
			state_q <= mmct_pkg::MMCT_INIT;
			tmr_q <= 32'h0;
			not_ready_q <= 1'h1;
			ready_attn_q <= 1'h0;
			bus_ready_q <= 1'h0;
		end
		else if (mod_rst_q)
		begin
			state_q <= mmct_pkg::MMCT_INIT;
			tmr_q <= 32'h0;
			not_ready_q <= 1'h1;
			ready_attn_q <= 1'h0;
			bus_ready_q <= 1'h0;
		end
		else
		begin
			if (evt.rd_pulse)
				ready_attn_q <= 1'h0; // R8
			case (state_q)
			mmct_pkg::MMCT_INIT:
			begin
				tmr_q <= tmr_q + 32'h1; // R21
				if (tmr_q >= 32'(INIT_CYC - 2)) // R1 R3 R5
				begin
					bus_ready_q <= 1'h1; // R3
					not_ready_q <= 1'h0; // R4
					ready_attn_q <= 1'h1; // R4 R18
					state_q <= mmct_pkg::MMCT_READY;
				end
			end
			mmct_pkg::MMCT_READY:
			begin
				tmr_q <= 32'h0;
				if (pd_eff_q || lp_eff_q)
					state_q <= mmct_pkg::MMCT_LOWPWR;
			end
			mmct_pkg::MMCT_LOWPWR:
			begin
				tmr_q <= 32'h0;
				if (!pd_eff_q && !lpreq_s_q)
					state_q <= mmct_pkg::MMCT_WAKE;
			end
			mmct_pkg::MMCT_WAKE:
			begin
				tmr_q <= tmr_q + 32'h1;
				if (pd_eff_q || lp_eff_q)
					state_q <= mmct_pkg::MMCT_LOWPWR;
				else if (tmr_q >= 32'(PUP_CYC - 2)) // R17
					state_q <= mmct_pkg::MMCT_READY;
			end
			default:
				state_q <= mmct_pkg::MMCT_INIT;
			endcase
		end
	end

	// hardware pin request: acted on after a fraction of the limit
	always_ff @(posedge ref_clk_in or negedge rstn_q)
	begin
		if (!rstn_q)
		begin
			lp_cnt_q <= 12'h000;
			lp_eff_q <= 1'h0;
		end
		else if (!lpreq_s_q)
		begin
			lp_cnt_q <= 12'h000;
			lp_eff_q <= 1'h0;
		end
		else if (lp_cnt_q >= 12'(LP_CYC / 2)) // R6
			lp_eff_q <= 1'h1;
		else
			lp_cnt_q <= lp_cnt_q + 12'h001;
	end

	// software power-down, timed from the crossed write strobe
	always_ff @(posedge ref_clk_in or negedge rstn_q)
	begin
		if (!rstn_q)
		begin
			pd_cnt_q <= 32'h0;
			pd_eff_q <= 1'h0;
		end
		else if (!evt.pdown)
		begin
			pd_cnt_q <= 32'h0;
			pd_eff_q <= 1'h0;
		end
		else if (pd_cnt_q >= 32'(PDOWN_CYC / 2)) // R16 R19
			pd_eff_q <= 1'h1;
		else
			pd_cnt_q <= pd_cnt_q + 32'h1;
	end

	// select gating debounced by a short count, well under the limit
	always_ff @(posedge ref_clk_in or negedge rstn_q)
	begin
		if (!rstn_q)
		begin
			sel_cnt_q <= 12'h000;
			bus_respond_out <= 1'h0;
		end
		else if (!bus_ready_q)
		begin
			// a module reset silences the bus at once, not after the debounce
			sel_cnt_q <= 12'h000;
			bus_respond_out <= 1'h0; // R3
		end
		else if ((!sel_n_s_q && bus_ready_q) == bus_respond_out)
			sel_cnt_q <= 12'h000;
		else if (sel_cnt_q >= 12'(SEL_CYC / 4)) // R14 R15
		begin
			bus_respond_out <= !sel_n_s_q && bus_ready_q;
			sel_cnt_q <= 12'h000;
		end
		else
			sel_cnt_q <= sel_cnt_q + 12'h001;
	end

	// sticky flags; set wins over a read clear in the same cycle
	always_ff @(posedge ref_clk_in or negedge rstn_q)
	begin
		if (!rstn_q)
			flags_q <= 8'h00;
		else if (mod_rst_q)
			flags_q <= 8'h00;
		else if (evt.rd_pulse)
			flags_q <= cond_s; // R8 R20
		else
			flags_q <= flags_q | cond_s; // R9 R10 R11 R20
	end

	always_ff @(posedge ref_clk_in or negedge rstn_q)
	begin
		if (!rstn_q)
			attention_out_n_out <= 1'h1;
		else
			attention_out_n_out <= !(ready_attn_q || |(flags_q & ~evt.mask)); // R7 R12 R13 R20
	end

	always_ff @(posedge ref_clk_in or negedge rstn_q)
	begin
		if (!rstn_q)
		begin
			low_power_out <= 1'h0;
			fully_functional_out <= 1'h0;
			data_not_ready_out <= 1'h1;
			flags_out <= 8'h00;
		end
		else
		begin
			low_power_out <= state_q == mmct_pkg::MMCT_LOWPWR;
			fully_functional_out <= state_q == mmct_pkg::MMCT_READY; // R18
			data_not_ready_out <= not_ready_q;
			flags_out <= flags_q;
		end
	end
endmodule // mmct_top

// *** testbench/mmct_top_props.sv ***
`timescale 1ns/1ns
module mmct_top_props #(
	parameter int INIT_CYC = 200
) (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic module_reset_n_in,
	input wire logic low_power_request_in,
	input wire logic module_select_n_in,
	input wire logic [7:0] condition_in,
	input wire logic attention_out_n_out,
	input wire logic bus_respond_out,
	input wire logic low_power_out,
	input wire logic fully_functional_out,
	input wire logic data_not_ready_out,
	input wire logic [7:0] flags_out
);
	// margin covers the reset and pin synchronisers
	localparam int INIT_MAX = INIT_CYC + 8;
	int nr_cnt_q;
	always_ff @(posedge ref_clk_in or negedge rstn_in)
		if (!rstn_in)
			nr_cnt_q <= 0;
		else if (!data_not_ready_out || !module_reset_n_in)
			nr_cnt_q <= 0;
		else
			nr_cnt_q <= nr_cnt_q + 1;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	chk_init_bound: assert property (nr_cnt_q <= INIT_MAX)
		else $error("not ready for too long");
	chk_respond_ready: assert property (bus_respond_out |-> !data_not_ready_out)
		else $error("bus answered before init done");
	chk_ready_attn: assert property ($fell(data_not_ready_out) |-> ##[0:1] (!attention_out_n_out && fully_functional_out))
		else $error("ready without attention");
	chk_los_set: assert property (($rose(condition_in[0]) && !data_not_ready_out) |-> ##[1:5] flags_out[0])
		else $error("loss flag late");
	chk_txf_set: assert property (($rose(condition_in[1]) && !data_not_ready_out) |-> ##[1:5] flags_out[1])
		else $error("fault flag late");
	chk_attn_cause: assert property ($fell(attention_out_n_out) |-> (|flags_out) || $past(data_not_ready_out) || $past(data_not_ready_out, 2))
		else $error("attention without cause");
	chk_lp_pin: assert property (($rose(low_power_request_in) && fully_functional_out) |-> ##[1:1000] (low_power_out || !low_power_request_in))
		else $error("low power late");
	chk_sel_on: assert property (($fell(module_select_n_in) && fully_functional_out) |-> ##[1:1000] (bus_respond_out || module_select_n_in))
		else $error("select answer late");
	chk_sel_off: assert property ($rose(module_select_n_in) |-> ##[1:1000] (!bus_respond_out || !module_select_n_in))
		else $error("deselect late");
endmodule // mmct_top_props
bind mmct_top mmct_top_props #(.INIT_CYC(INIT_CYC)) u_props (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
	.module_reset_n_in(module_reset_n_in), .low_power_request_in(low_power_request_in),
	.module_select_n_in(module_select_n_in), .condition_in(condition_in), .attention_out_n_out(attention_out_n_out),
	.bus_respond_out(bus_respond_out), .low_power_out(low_power_out), .fully_functional_out(fully_functional_out),
	.data_not_ready_out(data_not_ready_out), .flags_out(flags_out));

// *** testbench/mmct_host_model.sv ***
`timescale 1ns/1ns
module mmct_host_model (
	input wire logic link_clk_in,
	output logic rd_done_out,
	output logic wr_done_out,
	output logic [7:0] mask_out,
	output logic pdown_out
);
	initial
	begin
		rd_done_out = 1'b0;
		wr_done_out = 1'b0;
		mask_out = 8'h5A;
		pdown_out = 1'b1;
	end
	// one link cycle stands for the stop of a transaction; gap keeps toggles apart
	task do_read();
		@(posedge link_clk_in) rd_done_out <= 1'b1;
		@(posedge link_clk_in) rd_done_out <= 1'b0;
		repeat (12) @(posedge link_clk_in);
	endtask
	task do_write(input logic [7:0] m, input logic p);
		@(posedge link_clk_in)
		begin
			mask_out <= m;
			pdown_out <= p;
			wr_done_out <= 1'b1;
		end
		// data is meaningless outside the strobe, so show the inverse
		@(posedge link_clk_in)
		begin
			wr_done_out <= 1'b0;
			mask_out <= ~m;
			pdown_out <= ~p;
		end
		repeat (12) @(posedge link_clk_in);
	endtask
endmodule // mmct_host_model

// *** testbench/tb_mmct_top.sv ***
`timescale 1ns/1ns
module tb_mmct_top;
	logic clk, link_clk, rstn, mrst_n, lpr, sel_n, rd, wr, pdown, attn_n, resp, lp, ff, dnr;
	logic [7:0] cond, mask, flags;
	int miscompares = 0;
	int total_checks = 0;
	int cyc = 0;
	mmct_top #(.INIT_CYC(200), .PUP_CYC(50), .PDOWN_CYC(40)) DUT (.ref_clk_in(clk), .rstn_in(rstn),
		.link_clk_in(link_clk), .module_reset_n_in(mrst_n), .low_power_request_in(lpr),
		.module_select_n_in(sel_n), .condition_in(cond), .flag_read_done_in(rd), .write_done_in(wr),
		.mask_wr_in(mask), .pdown_wr_in(pdown), .attention_out_n_out(attn_n), .bus_respond_out(resp),
		.low_power_out(lp), .fully_functional_out(ff), .data_not_ready_out(dnr), .flags_out(flags));
	mmct_host_model host (.link_clk_in(link_clk), .rd_done_out(rd), .wr_done_out(wr), .mask_out(mask),
		.pdown_out(pdown));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		link_clk = 1'b0;
		#17;
		forever #40 link_clk = ~link_clk;
	end
	task report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// far beyond the few thousand cycles the sequence needs
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 10000)
		begin
			miscompares++;
			report_and_stop();
		end
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task wait_ready();
		int n;
		n = 0;
		while (dnr !== 1'b0 && n < 400)
		begin
			wt(1);
			n++;
		end
		check(8'(n >= 190 && n <= 215), 8'h01);
		check(attn_n, 8'h00);
		check(ff, 8'h01);
	endtask
	initial
	begin
		rstn = 1'b0;
		mrst_n = 1'b1;
		lpr = 1'b0;
		sel_n = 1'b1;
		cond = 8'h00;
		wt(9);
		check(attn_n, 8'h01);
		check(dnr, 8'h01);
		check(flags, 8'h00);
		@(posedge clk) rstn <= 1'b1;
		wait_ready();
		host.do_read();
		wt(12);
		check(attn_n, 8'h01);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk) cond <= 8'h01 << i;
			wt(6);
			check(flags, 8'h01 << i);
			check(attn_n, 8'h00);
			@(posedge clk) cond <= 8'h00;
			wt(6);
			check(flags, 8'h01 << i);
			host.do_read();
			wt(12);
			check(flags, 8'h00);
			check(attn_n, 8'h01);
		end
		host.do_write(8'h02, 1'b0);
		wt(12);
		@(posedge clk) cond <= 8'h02;
		wt(6);
		check(flags, 8'h02);
		check(attn_n, 8'h01);
		host.do_write(8'h00, 1'b0);
		wt(12);
		check(attn_n, 8'h00);
		@(posedge clk) cond <= 8'h00;
		host.do_read();
		wt(12);
		check(attn_n, 8'h01);
		@(posedge clk) sel_n <= 1'b0;
		wt(300);
		check(resp, 8'h01);
		@(posedge clk) sel_n <= 1'b1;
		wt(300);
		check(resp, 8'h00);
		@(posedge clk) lpr <= 1'b1;
		wt(600);
		check({lp, ff}, 8'h02);
		@(posedge clk) lpr <= 1'b0;
		wt(60);
		check({lp, ff}, 8'h01);
		host.do_write(8'h00, 1'b1);
		wt(60);
		check({lp, ff}, 8'h02);
		host.do_write(8'h00, 1'b0);
		wt(70);
		check({lp, ff}, 8'h01);
		@(posedge clk) mrst_n <= 1'b0;
		wt(10);
		@(posedge clk) mrst_n <= 1'b1;
		wt(5);
		check({dnr, ff}, 8'h01);
		@(posedge clk) mrst_n <= 1'b0;
		wt(40);
		check(dnr, 8'h01);
		@(posedge clk) mrst_n <= 1'b1;
		wait_ready();
		@(posedge clk) rstn <= 1'b0;
		wt(3);
		check(attn_n, 8'h01);
		@(posedge clk) rstn <= 1'b1;
		wait_ready();
		report_and_stop();
	end
endmodule // tb_mmct_top
